/* File: src/exs_pkg.sv */
/*
  Package for the extended-instruction execution subset: opcodes, states,
  widths and reset values.
  Assumes the core decodes each instruction into one of these opcodes before
  it reaches the execution block.
*/
package exs_pkg;
  // ---------------------------------------------------------------
  // widths and reset values
  // ---------------------------------------------------------------
  localparam int EXS_DATA_W = 8;
  localparam int EXS_WORD_W = 16;
  localparam int EXS_ADDR_W = 16;
  localparam logic [7:0] EXS_LAST_PAGE = 8'hFF; // highest page of program memory
  localparam logic [7:0] EXS_BYTE_RST = 8'h00;
  localparam logic [15:0] EXS_ADDR_RST = 16'h0000;

  // ---------------------------------------------------------------
  // decoded opcodes
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NIBBLE_SWAP_TO_WORKING = 4'h0,
    OP_SKIP_IF_ZERO = 4'h1,
    OP_COPY_SKIP_IF_ZERO = 4'h2,
    OP_SKIP_IF_BIT_ZERO = 4'h3,
    OP_TABLE_READ_CURRENT_PAGE = 4'h4,
    OP_TABLE_READ_FINAL_PAGE = 4'h5,
    OP_INCREMENT_THEN_TABLE_READ = 4'h6,
    OP_INCREMENT_THEN_FINAL_PAGE_READ = 4'h7,
    OP_XOR_INTO_WORKING = 4'h8,
    OP_XOR_INTO_MEMORY = 4'h9
  } exs_op_t;

  // ---------------------------------------------------------------
  // sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_TABLE_WAIT = 2'b01,
    ST_DUMMY = 2'b10
  } exs_state_t;
endpackage

/* File: src/exs_core.sv */
/*
  Execution block for swap, skip, table-read and XOR extended instructions.
  Assumes the core presents the addressed data byte on mem_rdata in the cycle
  the instruction is offered, and program memory answers in the cycle that
  prog_re is high with the word on prog_rdata. The core applies mem_we to the
  addressed byte and inserts a dummy cycle when skip is seen.
*/
// What this block does
// - the nibble swap puts the byte's high nibble into the working low nibble and its low nibble into the high one, flags kept.
// - the byte skip test skips the next instruction when the addressed byte is zero.
// - every skip-type test takes two cycles, the second being a dummy cycle.
// - the copy-and-skip loads the byte into the working register and skips when it is zero.
// - the bit skip test skips only when the selected bit is zero.
// - the current-page table read fetches the word at current page and low pointer, low byte to memory, high byte to the latch.
// - the final-page table read does the same with the word taken from the last page.
// - the incrementing read bumps the low pointer first, then reads at high and low pointer.
// - the incrementing final-page read bumps the low pointer first, then reads the last page.
// - the XOR into working stores working XOR byte in working and sets zero from the result.
// - the XOR into memory writes working XOR byte back to memory and sets zero from the result.
// - skip tests, copy-and-skip and all table reads leave the flags unchanged.
`timescale 1ns/100ps
`default_nettype none
module exs_core
  import exs_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic instr_valid,
  input wire logic [3:0] instr_op,
  input wire logic [2:0] bit_sel,
  input wire logic [7:0] mem_rdata,
  input wire logic [7:0] pc_page,
  input wire logic [15:0] prog_rdata,
  input wire logic ptr_low_load,
  input wire logic ptr_high_load,
  input wire logic [7:0] ptr_wdata,
  output logic busy,
  output logic skip,
  output logic mem_we,
  output logic [7:0] mem_wdata,
  output logic prog_re,
  output logic [15:0] prog_addr,
  output logic [7:0] working,
  output logic zero_flag,
  output logic [7:0] table_pointer_low,
  output logic [7:0] table_pointer_high,
  output logic [7:0] table_high_byte_latch
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    exs_state_t st;
    logic busy;
    logic skip;
    logic mem_we;
    logic [7:0] mem_wdata;
    logic prog_re;
    logic [15:0] prog_addr;
    logic [7:0] working;
    logic zero;
    logic [7:0] tpl;
    logic [7:0] tph;
    logic [7:0] tbh;
  } exs_regs_t;

  exs_regs_t s_r;
  exs_regs_t s_nxt;
  logic take;
  exs_op_t op;

  // zero test shared by skips and flag updates
  function automatic logic exs_is_zero(input logic [7:0] v);
    exs_is_zero = (v == EXS_BYTE_RST);
  endfunction

  assign take = instr_valid && !s_r.busy;
  assign op = exs_op_t'(instr_op);

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb
  begin
    logic [7:0] x;
    x = s_r.working ^ mem_rdata;
    s_nxt = s_r;
    s_nxt.skip = 1'b0;
    s_nxt.mem_we = 1'b0;
    s_nxt.prog_re = 1'b0;
    // pointer loads from the core; an increment in the same cycle wins
    if (ptr_low_load)
    begin
      s_nxt.tpl = ptr_wdata;
    end
    if (ptr_high_load)
    begin
      s_nxt.tph = ptr_wdata;
    end
    case (s_r.st)
      ST_IDLE:
      begin
        if (take)
        begin
          case (op)
            OP_NIBBLE_SWAP_TO_WORKING:
            begin
              s_nxt.working = {mem_rdata[3:0], mem_rdata[7:4]};
            end
            OP_SKIP_IF_ZERO:
            begin
              s_nxt.skip = exs_is_zero(mem_rdata);
              s_nxt.st = ST_DUMMY;
              s_nxt.busy = 1'b1;
            end
            OP_COPY_SKIP_IF_ZERO:
            begin
              s_nxt.working = mem_rdata;
              s_nxt.skip = exs_is_zero(mem_rdata);
              s_nxt.st = ST_DUMMY;
              s_nxt.busy = 1'b1;
            end
            OP_SKIP_IF_BIT_ZERO:
            begin
              s_nxt.skip = !mem_rdata[bit_sel];
              s_nxt.st = ST_DUMMY;
              s_nxt.busy = 1'b1;
            end
            OP_TABLE_READ_CURRENT_PAGE, OP_TABLE_READ_FINAL_PAGE,
            OP_INCREMENT_THEN_TABLE_READ, OP_INCREMENT_THEN_FINAL_PAGE_READ:
            begin
              s_nxt.prog_re = 1'b1;
              s_nxt.st = ST_TABLE_WAIT;
              s_nxt.busy = 1'b1;
              case (op)
                OP_TABLE_READ_CURRENT_PAGE:
                  s_nxt.prog_addr = {pc_page, s_r.tpl};
                OP_TABLE_READ_FINAL_PAGE:
                  s_nxt.prog_addr = {EXS_LAST_PAGE, s_r.tpl};
                OP_INCREMENT_THEN_TABLE_READ:
                begin
                  s_nxt.tpl = s_r.tpl + 8'h01;
                  s_nxt.prog_addr = {s_r.tph, s_r.tpl + 8'h01};
                end
                default:
                begin
                  s_nxt.tpl = s_r.tpl + 8'h01;
                  s_nxt.prog_addr = {EXS_LAST_PAGE, s_r.tpl + 8'h01};
                end
              endcase
            end
            OP_XOR_INTO_WORKING:
            begin
              s_nxt.working = x;
              s_nxt.zero = exs_is_zero(x);
            end
            OP_XOR_INTO_MEMORY:
            begin
              s_nxt.mem_we = 1'b1;
              s_nxt.mem_wdata = x;
              s_nxt.zero = exs_is_zero(x);
            end
            default:
            begin
              s_nxt.st = ST_IDLE; // unknown opcodes do nothing
            end
          endcase
        end
      end
      ST_TABLE_WAIT:
      begin
        // word arrives now: low byte to memory, high byte to the latch
        s_nxt.mem_we = 1'b1;
        s_nxt.mem_wdata = prog_rdata[7:0];
        s_nxt.tbh = prog_rdata[15:8];
        s_nxt.st = ST_IDLE;
        s_nxt.busy = 1'b0;
      end
      ST_DUMMY:
      begin
        s_nxt.st = ST_IDLE; // second cycle of a skip test
        s_nxt.busy = 1'b0;
      end
      default:
      begin
        s_nxt.st = ST_IDLE;
        s_nxt.busy = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      s_r <= '{st: ST_IDLE, busy: 1'b0, skip: 1'b0, mem_we: 1'b0, mem_wdata: EXS_BYTE_RST,
               prog_re: 1'b0, prog_addr: EXS_ADDR_RST, working: EXS_BYTE_RST, zero: 1'b0,
               tpl: EXS_BYTE_RST, tph: EXS_BYTE_RST, tbh: EXS_BYTE_RST};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign busy = s_r.busy;
  assign skip = s_r.skip;
  assign mem_we = s_r.mem_we;
  assign mem_wdata = s_r.mem_wdata;
  assign prog_re = s_r.prog_re;
  assign prog_addr = s_r.prog_addr;
  assign working = s_r.working;
  assign zero_flag = s_r.zero;
  assign table_pointer_low = s_r.tpl;
  assign table_pointer_high = s_r.tph;
  assign table_high_byte_latch = s_r.tbh;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence take_op(logic [3:0] o);
    instr_valid && !busy && instr_op == o;
  endsequence

  // second step of a table read: low byte written, high byte latched, idle again
  sequence table_finish;
    mem_we && !busy && mem_wdata == $past(prog_rdata[7:0])
    && table_high_byte_latch == $past(prog_rdata[15:8]);
  endsequence

  chk_swap_nibbles: assert property (take_op(OP_NIBBLE_SWAP_TO_WORKING) |=>
    working == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])} && $stable(zero_flag) && !mem_we)
    else $error("nibble swap result wrong");
  chk_byte_skip: assert property (take_op(OP_SKIP_IF_ZERO) |=> skip == ($past(mem_rdata) == 8'h00))
    else $error("byte skip decision wrong");
  chk_skip_two_cycles: assert property ((take_op(OP_SKIP_IF_ZERO) or take_op(OP_COPY_SKIP_IF_ZERO)
    or take_op(OP_SKIP_IF_BIT_ZERO)) |=> busy ##1 !busy)
    else $error("skip test not two cycles");
  chk_copy_skip: assert property (take_op(OP_COPY_SKIP_IF_ZERO) |=>
    working == $past(mem_rdata) && skip == ($past(mem_rdata) == 8'h00))
    else $error("copy and skip wrong");
  chk_bit_skip: assert property (take_op(OP_SKIP_IF_BIT_ZERO) |=> skip == !$past(mem_rdata[bit_sel]))
    else $error("bit skip decision wrong");
  chk_table_current: assert property (take_op(OP_TABLE_READ_CURRENT_PAGE) |=>
    (prog_re && prog_addr == {$past(pc_page), $past(table_pointer_low)}) ##1 table_finish)
    else $error("current page read wrong");
  chk_table_final: assert property (take_op(OP_TABLE_READ_FINAL_PAGE) |=>
    (prog_re && prog_addr == {EXS_LAST_PAGE, $past(table_pointer_low)}) ##1 table_finish)
    else $error("final page read wrong");
  chk_incr_read: assert property (take_op(OP_INCREMENT_THEN_TABLE_READ) |=>
    (prog_re && table_pointer_low == $past(table_pointer_low) + 8'h01
     && prog_addr == {$past(table_pointer_high), table_pointer_low}) ##1 table_finish)
    else $error("incrementing read wrong");
  chk_incr_final: assert property (take_op(OP_INCREMENT_THEN_FINAL_PAGE_READ) |=>
    (prog_re && table_pointer_low == $past(table_pointer_low) + 8'h01
     && prog_addr == {EXS_LAST_PAGE, table_pointer_low}) ##1 table_finish)
    else $error("incrementing final page read wrong");
  chk_xor_working: assert property (take_op(OP_XOR_INTO_WORKING) |=>
    working == ($past(working) ^ $past(mem_rdata)) && zero_flag == (working == 8'h00))
    else $error("xor into working wrong");
  chk_xor_memory: assert property (take_op(OP_XOR_INTO_MEMORY) |=>
    mem_we && mem_wdata == ($past(working) ^ $past(mem_rdata)) && zero_flag == (mem_wdata == 8'h00)
    && $stable(working))
    else $error("xor into memory wrong");
  chk_flags_kept: assert property (instr_valid && !busy && instr_op inside {[4'h1:4'h7]} |=>
    $stable(zero_flag) ##1 $stable(zero_flag))
    else $error("flag changed by skip or table read");

endmodule
`default_nettype wire

/* File: sim/exs_core_tb.sv */
/*
  Self-checking bench for the swap, skip, table-read and XOR execution block.
  Assumes a single 40 MHz clock; the bench plays core and both memories.
*/
`timescale 1ns/100ps
`default_nettype none
module exs_core_tb;
  import exs_pkg::*;
  // ---------------------------------------------------------------
  // stimulus signals and reference state
  // ---------------------------------------------------------------
  logic clk = 1'b0, reset = 1'b1, instr_valid = 1'b0, ptr_low_load = 1'b0, ptr_high_load = 1'b0;
  logic [3:0] instr_op = 4'h0;
  logic [2:0] bit_sel = 3'h0;
  logic [7:0] mem_rdata = 8'h00, pc_page = 8'h00, ptr_wdata = 8'h00;
  logic [15:0] prog_rdata = 16'h0000;
  logic busy, skip, mem_we, prog_re, zero_flag;
  logic [7:0] mem_wdata, working, table_pointer_low, table_pointer_high, table_high_byte_latch;
  logic [15:0] prog_addr;
  logic [7:0] w = 8'h00, tpl, tph;
  logic z = 1'b0;
  int miscompares = 0, n_checks = 0;

  exs_core exs_core_i (.clk(clk), .reset(reset), .instr_valid(instr_valid), .instr_op(instr_op),
    .bit_sel(bit_sel), .mem_rdata(mem_rdata), .pc_page(pc_page), .prog_rdata(prog_rdata),
    .ptr_low_load(ptr_low_load), .ptr_high_load(ptr_high_load), .ptr_wdata(ptr_wdata),
    .busy(busy), .skip(skip), .mem_we(mem_we), .mem_wdata(mem_wdata), .prog_re(prog_re),
    .prog_addr(prog_addr), .working(working), .zero_flag(zero_flag),
    .table_pointer_low(table_pointer_low), .table_pointer_high(table_pointer_high),
    .table_high_byte_latch(table_high_byte_latch));

  // 25 ns clock
  always #12.5 clk = ~clk;

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // offer one instruction after an idle cycle, return in the cycle after it is taken
  task automatic issue(input logic [3:0] op, input logic [7:0] m);
    @(negedge clk);
    instr_valid = 1'b1;
    instr_op = op;
    mem_rdata = m;
    @(negedge clk);
    instr_valid = 1'b0;
    mem_rdata = ~m;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic do_swap(input logic [7:0] m);
    issue(OP_NIBBLE_SWAP_TO_WORKING, m);
    w = {m[3:0], m[7:4]};
    check({7'h00, mem_we, working}, {8'h00, w});
    check(16'(zero_flag), 16'(z));
  endtask

  task automatic do_xor(input logic [3:0] op, input logic [7:0] m);
    issue(op, m);
    z = ((w ^ m) == 8'h00);
    if (op == OP_XOR_INTO_MEMORY)
      check({7'h00, mem_we, mem_wdata}, {8'h01, w ^ m});
    else
      w = w ^ m;
    check(16'(working), 16'(w));
    check(16'(zero_flag), 16'(z));
  endtask

  // skip test; a second instruction offered while busy must be ignored
  task automatic do_skip(input logic [3:0] op, input logic [7:0] m, input logic [2:0] b, input logic s);
    @(negedge clk);
    instr_valid = 1'b1;
    instr_op = op;
    mem_rdata = m;
    bit_sel = b;
    @(negedge clk);
    instr_op = OP_XOR_INTO_WORKING;
    mem_rdata = 8'hFF;
    if (op == OP_COPY_SKIP_IF_ZERO)
      w = m;
    check(16'(busy), 16'h0001);
    check(16'(skip), 16'(s));
    @(negedge clk);
    instr_valid = 1'b0;
    check(16'({busy, skip}), 16'h0000);
    check(16'(working), 16'(w));
    check(16'(zero_flag), 16'(z));
  endtask

  task automatic load_ptr(input logic [7:0] lo, input logic [7:0] hi);
    ptr_low_load = 1'b1;
    ptr_wdata = lo;
    @(negedge clk);
    ptr_low_load = 1'b0;
    ptr_high_load = 1'b1;
    ptr_wdata = hi;
    @(negedge clk);
    ptr_high_load = 1'b0;
    tpl = lo;
    tph = hi;
    check({table_pointer_high, table_pointer_low}, {hi, lo});
  endtask

  task automatic do_tab(input logic [3:0] op, input logic [7:0] pg, input logic [15:0] word);
    logic [7:0] page;
    if (op == OP_INCREMENT_THEN_TABLE_READ || op == OP_INCREMENT_THEN_FINAL_PAGE_READ)
      tpl = tpl + 8'h01;
    page = (op == OP_TABLE_READ_CURRENT_PAGE) ? pg : (op == OP_INCREMENT_THEN_TABLE_READ) ? tph : EXS_LAST_PAGE;
    pc_page = pg;
    issue(op, 8'h00);
    prog_rdata = word;
    check(16'({prog_re, busy}), 16'h0003);
    check(prog_addr, {page, tpl});
    @(negedge clk);
    prog_rdata = ~word;
    check({7'h00, mem_we, mem_wdata}, {8'h01, word[7:0]});
    check(16'(table_high_byte_latch), 16'(word[15:8]));
    check(16'(table_pointer_low), 16'(tpl));
    check(16'({busy, zero_flag, working}), 16'({1'b0, z, w}));
  endtask

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    repeat (8) @(negedge clk);
    reset = 1'b0;
    check({7'h00, zero_flag, working}, 16'h0000);
    check({table_pointer_high, table_pointer_low}, 16'h0000);
    check({4'h0, busy, skip, mem_we, prog_re, table_high_byte_latch}, 16'h0000);
    load_ptr(8'hFF, 8'h12);
    do_swap(8'h3C);
    do_xor(OP_XOR_INTO_WORKING, 8'hC3);
    do_swap(8'hA5);
    do_xor(OP_XOR_INTO_MEMORY, 8'h5A);
    do_xor(OP_XOR_INTO_MEMORY, 8'h0F);
    do_skip(OP_SKIP_IF_ZERO, 8'h00, 3'h0, 1'b1);
    do_skip(OP_SKIP_IF_ZERO, 8'h01, 3'h0, 1'b0);
    do_skip(OP_COPY_SKIP_IF_ZERO, 8'h00, 3'h0, 1'b1);
    do_skip(OP_COPY_SKIP_IF_ZERO, 8'h80, 3'h0, 1'b0);
    do_skip(OP_SKIP_IF_BIT_ZERO, 8'hFE, 3'h0, 1'b1);
    do_skip(OP_SKIP_IF_BIT_ZERO, 8'hFE, 3'h1, 1'b0);
    do_tab(OP_TABLE_READ_CURRENT_PAGE, 8'h34, 16'hBEEF);
    do_tab(OP_INCREMENT_THEN_TABLE_READ, 8'h34, 16'h1357);
    do_tab(OP_TABLE_READ_FINAL_PAGE, 8'h34, 16'hA55A);
    do_tab(OP_INCREMENT_THEN_FINAL_PAGE_READ, 8'h34, 16'h0F0F);
    close_out();
  end

  initial
  begin
    #(25 * 400);
    miscompares++;
    close_out();
  end
endmodule
`default_nettype wire
